// ==== chff_consts.svh ====
// Offsets, field positions, reset values and event layout constants
`ifndef CHFF_CONSTS_SVH
`define CHFF_CONSTS_SVH

// Register offsets on the serial bus
`define CHFF_OFS_FAULT_FLAGS_ZERO   8'h26
`define CHFF_OFS_FAULT_FLAGS_ONE    8'h27
`define CHFF_OFS_EVENT_MASK_ZERO    8'h28

// Reset values
`define CHFF_RST_FAULT_FLAGS_ZERO   8'h00
`define CHFF_RST_FAULT_FLAGS_ONE    8'h00
`define CHFF_RST_EVENT_MASK_ZERO    8'h00

// Implemented bits of the second fault flag register (3, 1, 0 reserved)
`define CHFF_FF1_USED_MASK          8'hF4

// Serial bus target address, arbitrary value
`define CHFF_I2C_ADDR               7'h2A

// Event vector layout
`define CHFF_EVT_COUNT              26
`define CHFF_EVT_FF0_LSB            0
`define CHFF_EVT_FF1_LSB            8
`define CHFF_EVT_MSK_LSB            16
`define CHFF_EVT_REV_CURRENT        25
`define CHFF_EVT_REV_VOLTAGE        24
// Events that fire on both edges: bit 7, power good, three presence inputs
`define CHFF_EVT_BOTH_EDGE          26'h00F0080

`endif

// ==== chff_pkg.sv ====
// Types shared by the fault flag and mask block
package chff_pkg;
    typedef logic [7:0] chff_byte_t;
    typedef enum logic [3:0] {
        CHFF_IDLE,
        CHFF_ADDR,
        CHFF_ACK_ADDR,
        CHFF_REG,
        CHFF_ACK_REG,
        CHFF_WDATA,
        CHFF_ACK_WDATA,
        CHFF_RDATA,
        CHFF_ACK_RDATA
    } chff_i2c_state_e;
endpackage

// ==== chff_evt_if.sv ====
// Carrier for raw detector levels and the derived event pulses
`timescale 1ns/10ps
`default_nettype none
`include "chff_consts.svh"
interface chff_evt_if;
    logic [`CHFF_EVT_COUNT-1:0] raw;    // Asynchronous detector levels
    logic [`CHFF_EVT_COUNT-1:0] pulse;  // One-cycle event pulses
    modport det  (input raw, output pulse);
    modport core (output raw, input pulse);
endinterface
`default_nettype wire

// ==== chff_evt_detect.sv ====
// Synchronises detector levels and turns edges into one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "chff_consts.svh"
module chff_evt_detect
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RESETN,
    // Events
    chff_evt_if.det   EVT
);
    import chff_pkg::*;

    localparam logic [`CHFF_EVT_COUNT-1:0] BOTH_EDGE = `CHFF_EVT_BOTH_EDGE;

    genvar i;
    generate
        for (i = 0; i < `CHFF_EVT_COUNT; i = i + 1)
        begin : g_evt
            logic meta;   // First sync stage, read only by the second
            logic sync;   // Second sync stage
            logic prev;   // Last synced value for edge detection

            // Two-stage synchroniser plus history
            always_ff @(posedge CLK or negedge RESETN)
            begin
                if (!RESETN)
                begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                    prev <= 1'b0;
                end
                else
                begin
                    meta <= EVT.raw[i];
                    sync <= meta;
                    prev <= sync;
                end
            end

            // Rising edge, or any edge for toggle-type events
            if (BOTH_EDGE[i])
            begin : g_both
                assign EVT.pulse[i] = sync ^ prev;
            end
            else
            begin : g_rise
                assign EVT.pulse[i] = sync & ~prev;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== chff_fault_flags.sv ====
// Fault flag latches, interrupt mask and serial register access
`timescale 1ns/10ps
`default_nettype none
`include "chff_consts.svh"
module chff_fault_flags
(
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    // Serial register bus
    input  wire logic                 SCL,
    input  wire logic                 SDA_IN,
    output logic                      SDA_OUT,
    output logic                      SDA_OE,
    // Fault detector levels, first register
    input  wire logic                 CHARGE_CURRENT_REG_ACTIVE,
    input  wire logic                 BUS_INPUT_OVERVOLT_ACTIVE,
    input  wire logic                 BATTERY_OVERVOLT_ACTIVE,
    input  wire logic                 INPUT_OVERCURRENT_ACTIVE,
    input  wire logic                 DISCHARGE_OVERCURRENT_ACTIVE,
    input  wire logic                 CONVERTER_OVERCURRENT_ACTIVE,
    input  wire logic                 SECOND_INPUT_OVERVOLT_ACTIVE,
    input  wire logic                 FIRST_INPUT_OVERVOLT_ACTIVE,
    // Fault detector levels, second register
    input  wire logic                 SYSTEM_RAIL_SHORT_ACTIVE,
    input  wire logic                 SYSTEM_RAIL_OVERVOLT_ACTIVE,
    input  wire logic                 REVERSE_OUT_OVERVOLT_ACTIVE,
    input  wire logic                 REVERSE_OUT_UNDERVOLT_ACTIVE,
    input  wire logic                 THERMAL_SHUTDOWN_ACTIVE,
    // Masked event sources
    input  wire logic                 INPUT_CURRENT_LIMITING,
    input  wire logic                 REVERSE_CURRENT_REGULATION,
    input  wire logic                 INPUT_VOLTAGE_LIMITING,
    input  wire logic                 REVERSE_VOLTAGE_REGULATION,
    input  wire logic                 WATCHDOG_EXPIRED,
    input  wire logic                 WEAK_SOURCE_DETECTED,
    input  wire logic                 POWER_GOOD,
    input  wire logic                 SECOND_INPUT_PRESENT,
    input  wire logic                 FIRST_INPUT_PRESENT,
    input  wire logic                 BUS_PRESENT,
    // Neighbouring register bank, same clock
    input  wire logic                 REG_RESET_CMD,
    input  wire chff_pkg::chff_byte_t FAULT0_IRQ_BLOCK,
    input  wire chff_pkg::chff_byte_t FAULT1_IRQ_BLOCK,
    // Interrupt request to the pin driver
    output logic                      IRQ_PULSE
);
    import chff_pkg::*;

    // Event carrier and registers
    chff_evt_if      evt ();
    chff_byte_t      fault_flags_zero;  // Latched faults, first register
    chff_byte_t      fault_flags_one;   // Latched faults, second register
    chff_byte_t      event_mask_zero;   // Interrupt block bits
    chff_byte_t      set0;              // New faults this cycle, first
    chff_byte_t      set1;              // New faults this cycle, second
    chff_byte_t      mask_evt;          // Masked-class events this cycle
    logic            clr0;              // Read of first flag register
    logic            clr1;              // Read of second flag register
    logic            wr_mask;           // Write to the mask register

    // Serial bus state
    chff_i2c_state_e state;             // Transfer phase
    logic            scl_meta;          // First sync stage of clock
    logic            scl_sync;          // Synced clock
    logic            scl_prev;          // Clock history
    logic            sda_meta;          // First sync stage of data
    logic            sda_sync;          // Synced data
    logic            sda_prev;          // Data history
    logic            scl_rise;          // Sample point
    logic            scl_fall;          // Drive point
    logic            start_cond;        // Start or repeated start
    logic            stop_cond;         // Stop
    logic [3:0]      bit_cnt;           // Bits taken in current byte
    chff_byte_t      rx_shift;          // Received byte
    chff_byte_t      tx_shift;          // Byte being sent
    chff_byte_t      reg_ptr;           // Register pointer
    logic            read_dir;          // Transfer direction, 1 = read
    logic            host_ack;          // Host acknowledged last byte
    logic            load_rd;           // Fetch a byte for sending
    logic            got8;              // Full byte received
    chff_byte_t      rd_byte;           // Byte the pointer selects

    // Register read multiplexer, reserved bits and unmapped offsets read zero
    function automatic chff_byte_t read_mux(input chff_byte_t ofs,
                                            input chff_byte_t f0,
                                            input chff_byte_t f1,
                                            input chff_byte_t m0);
        chff_byte_t v;
        v = 8'h00;
        if (ofs == `CHFF_OFS_FAULT_FLAGS_ZERO)
        begin
            v = f0;
        end
        else if (ofs == `CHFF_OFS_FAULT_FLAGS_ONE)
        begin
            v = f1 & `CHFF_FF1_USED_MASK;
        end
        else if (ofs == `CHFF_OFS_EVENT_MASK_ZERO)
        begin
            v = m0;
        end
        return v;
    endfunction

    // Detector levels into the carrier, reserved slots tied low
    assign evt.raw[`CHFF_EVT_FF0_LSB+7] = CHARGE_CURRENT_REG_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+6] = BUS_INPUT_OVERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+5] = BATTERY_OVERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+4] = INPUT_OVERCURRENT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+3] = DISCHARGE_OVERCURRENT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+2] = CONVERTER_OVERCURRENT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+1] = SECOND_INPUT_OVERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF0_LSB+0] = FIRST_INPUT_OVERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF1_LSB+7] = SYSTEM_RAIL_SHORT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF1_LSB+6] = SYSTEM_RAIL_OVERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF1_LSB+5] = REVERSE_OUT_OVERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF1_LSB+4] = REVERSE_OUT_UNDERVOLT_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF1_LSB+3] = 1'b0;
    assign evt.raw[`CHFF_EVT_FF1_LSB+2] = THERMAL_SHUTDOWN_ACTIVE;
    assign evt.raw[`CHFF_EVT_FF1_LSB+1] = 1'b0;
    assign evt.raw[`CHFF_EVT_FF1_LSB+0] = 1'b0;
    assign evt.raw[`CHFF_EVT_MSK_LSB+7] = INPUT_CURRENT_LIMITING;
    assign evt.raw[`CHFF_EVT_MSK_LSB+6] = INPUT_VOLTAGE_LIMITING;
    assign evt.raw[`CHFF_EVT_MSK_LSB+5] = WATCHDOG_EXPIRED;
    assign evt.raw[`CHFF_EVT_MSK_LSB+4] = WEAK_SOURCE_DETECTED;
    assign evt.raw[`CHFF_EVT_MSK_LSB+3] = POWER_GOOD;
    assign evt.raw[`CHFF_EVT_MSK_LSB+2] = SECOND_INPUT_PRESENT;
    assign evt.raw[`CHFF_EVT_MSK_LSB+1] = FIRST_INPUT_PRESENT;
    assign evt.raw[`CHFF_EVT_MSK_LSB+0] = BUS_PRESENT;
    assign evt.raw[`CHFF_EVT_REV_CURRENT] = REVERSE_CURRENT_REGULATION;
    assign evt.raw[`CHFF_EVT_REV_VOLTAGE] = REVERSE_VOLTAGE_REGULATION;

    // Synchronisers and edge detectors
    chff_evt_detect u_detect
    (
        .CLK    (CLK),
        .RESETN (RESETN),
        .EVT    (evt)
    );

    // Bit 7 fires on both edges, the rest on entry
    assign set0 = evt.pulse[`CHFF_EVT_FF0_LSB +: 8];
    // Reserved positions never set
    assign set1 = evt.pulse[`CHFF_EVT_FF1_LSB +: 8] & `CHFF_FF1_USED_MASK;

    // Shared mask bits combine input limiting and reverse regulation
    assign mask_evt[7]   = evt.pulse[`CHFF_EVT_MSK_LSB+7] | evt.pulse[`CHFF_EVT_REV_CURRENT];
    assign mask_evt[6]   = evt.pulse[`CHFF_EVT_MSK_LSB+6] | evt.pulse[`CHFF_EVT_REV_VOLTAGE];
    assign mask_evt[5:0] = evt.pulse[`CHFF_EVT_MSK_LSB +: 6];

    // Read clears and mask write strobes
    assign clr0    = load_rd && (reg_ptr == `CHFF_OFS_FAULT_FLAGS_ZERO);
    assign clr1    = load_rd && (reg_ptr == `CHFF_OFS_FAULT_FLAGS_ONE);
    assign wr_mask = (state == CHFF_WDATA) && scl_fall && got8
                     && (reg_ptr == `CHFF_OFS_EVENT_MASK_ZERO);

    // First flag register: a new event wins over the read clear
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            fault_flags_zero <= `CHFF_RST_FAULT_FLAGS_ZERO;
        end
        else
        begin
            fault_flags_zero <= set0 | (fault_flags_zero & ~{8{clr0}});
        end
    end

    // Second flag register, same latch and clear scheme
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            fault_flags_one <= `CHFF_RST_FAULT_FLAGS_ONE;
        end
        else
        begin
            fault_flags_one <= set1 | (fault_flags_one & ~{8{clr1}});
        end
    end

    // Mask register, the register-reset command beats a write
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            event_mask_zero <= `CHFF_RST_EVENT_MASK_ZERO;
        end
        else if (REG_RESET_CMD)
        begin
            event_mask_zero <= `CHFF_RST_EVENT_MASK_ZERO;
        end
        else if (wr_mask)
        begin
            event_mask_zero <= rx_shift;
        end
    end

    // Interrupt pulse for any unmasked event this cycle
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            IRQ_PULSE <= 1'b0;
        end
        else
        begin
            IRQ_PULSE <= (|(mask_evt & ~event_mask_zero))
                       | (|(set0 & ~FAULT0_IRQ_BLOCK))
                       | (|(set1 & ~FAULT1_IRQ_BLOCK));
        end
    end

    // Bus pins pass two flops before any logic looks at them
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            scl_meta <= SCL;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= SDA_IN;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    // Bus conditions from the synced pins
    assign scl_rise   = scl_sync & ~scl_prev;
    assign scl_fall   = ~scl_sync & scl_prev;
    assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;
    assign got8       = (bit_cnt == 4'h8);
    assign load_rd    = scl_fall && (((state == CHFF_ACK_ADDR) && read_dir)
                        || ((state == CHFF_ACK_RDATA) && host_ack));
    assign SDA_OUT    = 1'b0;
    assign rd_byte    = read_mux(reg_ptr, fault_flags_zero, fault_flags_one, event_mask_zero);

    // Bit sampling on the rising clock edge
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            bit_cnt  <= 4'h0;
            rx_shift <= 8'h00;
            host_ack <= 1'b0;
        end
        else if (start_cond || (scl_fall && !got8 && (state == CHFF_IDLE)))
        begin
            bit_cnt <= 4'h0;
        end
        else if (scl_fall && (got8 || (state == CHFF_ACK_ADDR)
                 || (state == CHFF_ACK_REG) || (state == CHFF_ACK_WDATA)
                 || (state == CHFF_ACK_RDATA)))
        begin
            bit_cnt <= 4'h0;
        end
        else if (scl_rise)
        begin
            // Count data bits, catch the host answer after a sent byte
            if (state == CHFF_ACK_RDATA)
            begin
                host_ack <= ~sda_sync;
            end
            else if (!got8)
            begin
                bit_cnt  <= bit_cnt + 4'h1;
                rx_shift <= {rx_shift[6:0], sda_sync};
            end
        end
    end

    // Transfer phases and data line drive on the falling clock edge
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state    <= CHFF_IDLE;
            SDA_OE   <= 1'b0;
            read_dir <= 1'b0;
            reg_ptr  <= 8'h00;
            tx_shift <= 8'h00;
        end
        else if (start_cond)
        begin
            state  <= CHFF_ADDR;
            SDA_OE <= 1'b0;
        end
        else if (stop_cond)
        begin
            state  <= CHFF_IDLE;
            SDA_OE <= 1'b0;
        end
        else if (scl_fall)
        begin
            case (state)
                CHFF_ADDR:
                begin
                    // Acknowledge own address only
                    if (got8 && (rx_shift[7:1] == `CHFF_I2C_ADDR))
                    begin
                        read_dir <= rx_shift[0];
                        SDA_OE   <= 1'b1;
                        state    <= CHFF_ACK_ADDR;
                    end
                    else if (got8)
                    begin
                        state <= CHFF_IDLE;
                    end
                end
                CHFF_ACK_ADDR, CHFF_ACK_RDATA:
                begin
                    // Fetch next byte, read clears flags via load_rd
                    if (load_rd)
                    begin
                        tx_shift <= rd_byte;
                        SDA_OE   <= ~rd_byte[7];
                        reg_ptr  <= reg_ptr + 8'h01;
                        state    <= CHFF_RDATA;
                    end
                    else if (state == CHFF_ACK_ADDR)
                    begin
                        SDA_OE <= 1'b0;
                        state  <= CHFF_REG;
                    end
                    else
                    begin
                        SDA_OE <= 1'b0;
                        state  <= CHFF_IDLE;
                    end
                end
                CHFF_REG:
                begin
                    // Pointer byte
                    if (got8)
                    begin
                        reg_ptr <= rx_shift;
                        SDA_OE  <= 1'b1;
                        state   <= CHFF_ACK_REG;
                    end
                end
                CHFF_ACK_REG:
                begin
                    SDA_OE <= 1'b0;
                    state  <= CHFF_WDATA;
                end
                CHFF_WDATA:
                begin
                    // Data byte, stored by the mask write strobe
                    if (got8)
                    begin
                        SDA_OE <= 1'b1;
                        state  <= CHFF_ACK_WDATA;
                    end
                end
                CHFF_ACK_WDATA:
                begin
                    SDA_OE  <= 1'b0;
                    reg_ptr <= reg_ptr + 8'h01;
                    state   <= CHFF_WDATA;
                end
                CHFF_RDATA:
                begin
                    // Shift out, then release for the host answer
                    if (bit_cnt == 4'h8)
                    begin
                        SDA_OE <= 1'b0;
                        state  <= CHFF_ACK_RDATA;
                    end
                    else
                    begin
                        SDA_OE   <= ~tx_shift[6];
                        tx_shift <= {tx_shift[6:0], 1'b0};
                    end
                end
                default:
                begin
                    SDA_OE <= 1'b0;
                    state  <= CHFF_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== chff_host.sv ====
// Serial bus host model: drives the clock and pulls the open-drain data line
`timescale 1ns/10ps
`default_nettype none
`include "chff_consts.svh"
module chff_host
(
    // Clock
    input  wire logic CLK,
    // Serial bus
    output logic      SCL,
    output logic      SDA_PULL,
    input  wire logic SDA
);
    int nacks = 0; // Missing acknowledges seen
    // Idle bus: clock high, data released
    initial
    begin
        SCL = 1'b1;
        SDA_PULL = 1'b0;
    end
    // Wait n core cycles, then step just past the edge
    task automatic hb(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // One bit: set data, low phase, high phase, sample at its end, clock falls
    task automatic bit_x(input logic b, output logic r);
        SDA_PULL = !b;
        hb(10);
        SCL = 1'b1;
        hb(10);
        r = SDA;
        SCL = 1'b0;
        hb(1);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        SDA_PULL = 1'b0;
        hb(10);
        SCL = 1'b1;
        hb(10);
        SDA_PULL = 1'b1;
        hb(10);
        SCL = 1'b0;
        hb(10);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        SDA_PULL = 1'b1;
        hb(10);
        SCL = 1'b1;
        hb(10);
        SDA_PULL = 1'b0;
        hb(10);
    endtask
    // Byte out, most significant bit first, then acknowledge slot
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        if (r) nacks++;
    endtask
    // Byte in, then a not-acknowledge to end the read
    task automatic rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(1'b1, r);
    endtask
    // Register write through the pointer
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        start();
        tx({`CHFF_I2C_ADDR, 1'b0});
        tx(o);
        tx(d);
        stop();
    endtask
    // Register read: pointer write, repeated start, one byte
    task automatic rd(input logic [7:0] o, output logic [7:0] d);
        start();
        tx({`CHFF_I2C_ADDR, 1'b0});
        tx(o);
        start();
        tx({`CHFF_I2C_ADDR, 1'b1});
        rx(d);
        stop();
    endtask
endmodule
`default_nettype wire

// ==== chff_fault_flags_chk.sv ====
// Port-level checker for the fault flag block
`timescale 1ns/10ps
`default_nettype none
module chff_chk
(
    // Clock, reset, serial bus
    input wire logic                 CLK,
    input wire logic                 RESETN,
    input wire logic                 SCL,
    input wire logic                 SDA_OUT,
    input wire logic                 SDA_OE,
    // Event levels, blocks, interrupt
    input wire logic                 CHARGE_CURRENT_REG_ACTIVE,
    input wire logic                 BUS_INPUT_OVERVOLT_ACTIVE,
    input wire logic                 SYSTEM_RAIL_SHORT_ACTIVE,
    input wire logic                 THERMAL_SHUTDOWN_ACTIVE,
    input wire chff_pkg::chff_byte_t FAULT0_IRQ_BLOCK,
    input wire chff_pkg::chff_byte_t FAULT1_IRQ_BLOCK,
    input wire logic                 IRQ_PULSE
);
    import chff_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Unblocked events must raise the interrupt within the sync delay
    property p_creg; $changed(CHARGE_CURRENT_REG_ACTIVE) && !FAULT0_IRQ_BLOCK[7]
        |-> ##[1:4] IRQ_PULSE; endproperty
    a_creg: assert property (p_creg) else $error("no irq on regulation change");
    property p_ovp; $rose(BUS_INPUT_OVERVOLT_ACTIVE) && !FAULT0_IRQ_BLOCK[6]
        |-> ##[1:4] IRQ_PULSE; endproperty
    a_ovp: assert property (p_ovp) else $error("no irq on bus overvoltage");
    property p_short; $rose(SYSTEM_RAIL_SHORT_ACTIVE) && !FAULT1_IRQ_BLOCK[7]
        |-> ##[1:4] IRQ_PULSE; endproperty
    a_short: assert property (p_short) else $error("no irq on rail short");
    property p_tshut; $rose(THERMAL_SHUTDOWN_ACTIVE) && !FAULT1_IRQ_BLOCK[2]
        |-> ##[1:4] IRQ_PULSE; endproperty
    a_tshut: assert property (p_tshut) else $error("no irq on thermal shutdown");
    // Quiet interrupt just after reset release
    property p_rst; $rose(RESETN) |-> !IRQ_PULSE [*2]; endproperty
    a_rst: assert property (p_rst) else $error("irq right after reset");
    // Data drive moves only while the serial clock is low, and only ever pulls the line low
    property p_oe_scl; $changed(SDA_OE) |-> !SCL; endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("data drive moved with clock high");
    property p_oe_late; $fell(SCL) |-> $stable(SDA_OE) [*2]; endproperty
    a_oe_late: assert property (p_oe_late) else $error("data drive moved too early");
    property p_sda_low; SDA_OE |-> SDA_OUT == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data line driven high");
    // Main scenarios
    c_irq: cover property (IRQ_PULSE);
    c_ack: cover property ($rose(SDA_OE));
    c_tshut: cover property ($rose(THERMAL_SHUTDOWN_ACTIVE));
endmodule
bind chff_fault_flags chff_chk i_chk (.CLK, .RESETN, .SCL, .SDA_OUT, .SDA_OE,
    .CHARGE_CURRENT_REG_ACTIVE, .BUS_INPUT_OVERVOLT_ACTIVE, .SYSTEM_RAIL_SHORT_ACTIVE,
    .THERMAL_SHUTDOWN_ACTIVE, .FAULT0_IRQ_BLOCK, .FAULT1_IRQ_BLOCK, .IRQ_PULSE);
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the fault flag and mask block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, id, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s %0h exp %h got %h", nm, id, e, g); end end
module testbench;
    import chff_pkg::*;
    logic        CLK = 1'b0; // Core clock
    logic        RESETN;     // Reset, active low
    logic        scl;        // Serial clock
    logic        pull;       // Host pulls data low
    logic        sda_oe;     // Device pulls data low
    logic        sda_out;    // Device data level
    logic        irq;        // Interrupt pulse
    logic        rrc;        // Register-reset command
    chff_byte_t  b0;         // Fault interrupt blocks
    chff_byte_t  b1;
    logic [22:0] lv;         // Detector levels
    logic [7:0]  rdat;       // Read data
    int          err_total = 0;
    int          num_checks = 0;
    int          mb[10] = '{7, 7, 6, 6, 5, 4, 3, 2, 1, 0}; // Mask bit of each source
    wire         sda = !(pull | sda_oe); // Pulled-up data line
    always #25 CLK = !CLK;
    chff_fault_flags i_dut (.CLK(CLK), .RESETN(RESETN), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CHARGE_CURRENT_REG_ACTIVE(lv[7]),
        .BUS_INPUT_OVERVOLT_ACTIVE(lv[6]), .BATTERY_OVERVOLT_ACTIVE(lv[5]),
        .INPUT_OVERCURRENT_ACTIVE(lv[4]), .DISCHARGE_OVERCURRENT_ACTIVE(lv[3]),
        .CONVERTER_OVERCURRENT_ACTIVE(lv[2]), .SECOND_INPUT_OVERVOLT_ACTIVE(lv[1]),
        .FIRST_INPUT_OVERVOLT_ACTIVE(lv[0]), .THERMAL_SHUTDOWN_ACTIVE(lv[8]),
        .REVERSE_OUT_UNDERVOLT_ACTIVE(lv[9]), .REVERSE_OUT_OVERVOLT_ACTIVE(lv[10]),
        .SYSTEM_RAIL_OVERVOLT_ACTIVE(lv[11]), .SYSTEM_RAIL_SHORT_ACTIVE(lv[12]),
        .INPUT_CURRENT_LIMITING(lv[13]), .REVERSE_CURRENT_REGULATION(lv[14]),
        .INPUT_VOLTAGE_LIMITING(lv[15]), .REVERSE_VOLTAGE_REGULATION(lv[16]),
        .WATCHDOG_EXPIRED(lv[17]), .WEAK_SOURCE_DETECTED(lv[18]), .POWER_GOOD(lv[19]),
        .SECOND_INPUT_PRESENT(lv[20]), .FIRST_INPUT_PRESENT(lv[21]), .BUS_PRESENT(lv[22]),
        .REG_RESET_CMD(rrc), .FAULT0_IRQ_BLOCK(b0), .FAULT1_IRQ_BLOCK(b1), .IRQ_PULSE(irq));
    chff_host i_host (.CLK(CLK), .SCL(scl), .SDA_PULL(pull), .SDA(sda));
    // Read a register and compare
    task automatic rd_chk(input logic [7:0] o, input logic [7:0] e);
        i_host.rd(o, rdat);
        `CHK("register", o, e, rdat)
    endtask
    // Move one level, count the interrupt pulses that follow
    task automatic ev(input int i, input logic v, input int e);
        int n;
        n = 0;
        @(posedge CLK);
        #1 lv[i] = v;
        repeat (8)
        begin
            @(posedge CLK);
            #1 if (irq !== 1'b0) n++;
        end
        `CHK("irq count", i, e, n)
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        RESETN = 1'b0;
        rrc = 1'b0;
        b0 = 8'h00;
        b1 = 8'h00;
        lv = '0;
        repeat (3) @(posedge CLK);
        #1 RESETN = 1'b1;
        repeat (3) @(posedge CLK);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h27, 8'h00);
        rd_chk(8'h28, 8'h00);
        rd_chk(8'h30, 8'h00); // Unmapped offset
        for (int i = 0; i < 13; i++) ev(i, 1'b1, 1);
        rd_chk(8'h26, 8'hFF);
        rd_chk(8'h27, 8'hF4);
        rd_chk(8'h26, 8'h00);
        @(posedge CLK);
        #1 b0 = 8'hFF;
        b1 = 8'hFF;
        for (int i = 0; i < 13; i++) ev(i, 1'b0, 0); // Blocked falls
        rd_chk(8'h26, 8'h80);
        rd_chk(8'h27, 8'h00);
        for (int k = 0; k < 10; k++)
        begin
            i_host.wr(8'h28, 8'h01 << mb[k]);
            ev(13 + k, 1'b1, 0);
            ev(13 + k, 1'b0, 0);
            i_host.wr(8'h28, ~(8'h01 << mb[k]));
            ev(13 + k, 1'b1, 1);
            ev(13 + k, 1'b0, int'(k > 5));
        end
        rd_chk(8'h28, 8'hFE);
        i_host.wr(8'h27, 8'h55);
        rd_chk(8'h27, 8'h00);
        @(posedge CLK);
        #1 rrc = 1'b1;
        @(posedge CLK);
        #1 rrc = 1'b0;
        rd_chk(8'h28, 8'h00);
        `CHK("nacks", 0, 0, i_host.nacks)
        end_of_test();
    end
endmodule
`default_nettype wire
